// >>> src/ghb_pkg.sv
package ghb_pkg;

  // ---------------------------------------------------------------------------
  // strap layout and codes
  // ---------------------------------------------------------------------------
  localparam int unsigned STRAP_W        = 5;
  localparam int unsigned ENDIAN_BIT     = 3;
  localparam logic [2:0]  IFTYPE_GENERIC = 3'h7;

  // ---------------------------------------------------------------------------
  // address map
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W         = 16;
  localparam int unsigned HOST_ADDR_W    = 26;
  localparam logic [15:0] MEM_LAST       = 16'h9fff;
  localparam logic [15:0] REG_FIRST      = 16'hffe0;
  localparam logic [31:0] WIN_SLOT1_BASE = 32'h0900_0000;
  localparam logic [31:0] WIN_SLOT2_BASE = 32'h0d00_0000;

  // ---------------------------------------------------------------------------
  // timing: hold of the strap sampler after reset release
  // ---------------------------------------------------------------------------
  localparam int unsigned STRAP_SETTLE_NS = 100;
  localparam int unsigned CLK_PERIOD_NS   = 20;
  localparam int unsigned STRAP_SETTLE_CYC =
    (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    GHB_STYLE_NONE = 2'b00,
    GHB_STYLE_ONE  = 2'b01,
    GHB_STYLE_TWO  = 2'b10
  } ghb_style_t;

  typedef struct packed {
    logic       valid;
    ghb_style_t style;
    logic       big_endian;
  } ghb_cfg_t;

  // active-high decoded strobes, one set for each byte lane
  typedef struct packed {
    logic rd_hi;
    logic rd_lo;
    logic wr_hi;
    logic wr_lo;
  } ghb_strb_t;

  typedef struct packed {
    logic        mem_hit;
    logic        reg_hit;
    logic [15:0] offset;
  } ghb_dec_t;

endpackage

// >>> src/ghb_sync2.sv
`timescale 1ns/10ps
`default_nettype none

// -----------------------------------------------------------------------------
// two-stage synchroniser for a bundle of pin levels
// -----------------------------------------------------------------------------
module ghb_sync2 #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         resetn_i,
  input  wire logic         ce_i,
  // levels
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  // first stage is read only by the second
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else if (ce_i) begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule

`default_nettype wire

// >>> src/ghb_host_port.sv
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - sample config straps once, then keep them
// - style select high gives style two
// - interface straps 111 enable generic styles
// - endian strap high means big endian
// - style two: byte-high enable, read, write
// - style one: four separate byte strobes
// - host strobes asynchronous, synchronised internally
// - 64K space repeats 256 times in window
// - memory 0..9fff, registers ffe0..ffff, alias rest
module ghb_host_port (
  // clock, reset, enable
  input  wire logic                        clk_sys_i,
  input  wire logic                        resetn_i,
  input  wire logic                        ce_i,
  // straps
  input  wire logic [4:0]                  config_straps_i,
  input  wire logic                        bus_style_select_i,
  // host pins, strobes active low
  input  wire logic                        high_byte_write_strobe_n_i,
  input  wire logic                        low_byte_write_strobe_n_i,
  input  wire logic                        read_n_i,
  input  wire logic                        read_write_n_i,
  input  wire logic [ghb_pkg::HOST_ADDR_W-1:0] addr_i,
  // configuration out
  output var ghb_pkg::ghb_cfg_t            cfg_o,
  // decoded access out
  output var ghb_pkg::ghb_strb_t           strb_o,
  output var ghb_pkg::ghb_dec_t            dec_o,
  output logic                             rd_start_o,
  output logic                             wr_start_o
);

  // ---------------------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------------------
  logic [5:0] strap_s;
  logic [3:0] pin_s;
  logic [ghb_pkg::ADDR_W-1:0] addr_s;

  ghb_sync2 #(.W(6)) u_sync_strap (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .ce_i      (ce_i),
    .d_i       ({bus_style_select_i, config_straps_i}),
    .q_o       (strap_s)
  );

  // strobes arrive with no relation to our clock
  ghb_sync2 #(.W(4)) u_sync_pin (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .ce_i      (ce_i),
    .d_i       ({~high_byte_write_strobe_n_i, ~low_byte_write_strobe_n_i,
                 ~read_n_i, ~read_write_n_i}),
    .q_o       (pin_s)
  );

  // address passes the same two stages, so it lines up with the strobes
  ghb_sync2 #(.W(ghb_pkg::ADDR_W)) u_sync_addr (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .ce_i      (ce_i),
    .d_i       (addr_i[ghb_pkg::ADDR_W-1:0]),
    .q_o       (addr_s)
  );

  // ---------------------------------------------------------------------------
  // strap capture
  // ---------------------------------------------------------------------------
  localparam logic [3:0] SETTLE = 4'(ghb_pkg::STRAP_SETTLE_CYC);

  typedef enum logic [1:0] {
    GHB_ST_SETTLE = 2'b00,
    GHB_ST_LATCH  = 2'b01,
    GHB_ST_RUN    = 2'b10
  } ghb_cap_t;

  ghb_cap_t   cap_q;
  logic [3:0] settle_q;

  // wait a few cycles so the strap synchroniser has filled
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cap_q    <= GHB_ST_SETTLE;
      settle_q <= '0;
    end else if (ce_i) begin
      case (cap_q)
        GHB_ST_SETTLE: begin
          settle_q <= settle_q + 4'h1;
          if (settle_q == SETTLE) begin
            cap_q <= GHB_ST_LATCH;
          end
        end
        GHB_ST_LATCH: cap_q <= GHB_ST_RUN;
        GHB_ST_RUN:   cap_q <= GHB_ST_RUN;
        default:      cap_q <= GHB_ST_SETTLE;
      endcase
    end
  end

  // straps are taken once; later pin wiggles have no effect
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_o <= '0;
    end else if (ce_i && cap_q == GHB_ST_LATCH) begin
      cfg_o.valid      <= 1'b1;
      cfg_o.big_endian <= strap_s[ghb_pkg::ENDIAN_BIT];
      if (strap_s[2:0] == ghb_pkg::IFTYPE_GENERIC) begin
        cfg_o.style <= strap_s[5] ? ghb_pkg::GHB_STYLE_TWO
                                  : ghb_pkg::GHB_STYLE_ONE;
      end else begin
        cfg_o.style <= ghb_pkg::GHB_STYLE_NONE;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // strobe mapping per style
  // ---------------------------------------------------------------------------
  function automatic ghb_pkg::ghb_strb_t map_strb(input ghb_pkg::ghb_style_t st,
                                                  input logic [3:0] p);
    ghb_pkg::ghb_strb_t s;
    s = '0;
    case (st)
      // p = {we_hi, we_lo, rd, rdwr}
      ghb_pkg::GHB_STYLE_TWO: begin
        s.rd_lo = p[1];
        s.rd_hi = p[1] & p[3];
        s.wr_lo = p[2];
        s.wr_hi = p[2] & p[3];
      end
      ghb_pkg::GHB_STYLE_ONE: begin
        s.rd_hi = p[0];
        s.rd_lo = p[1];
        s.wr_hi = p[3];
        s.wr_lo = p[2];
      end
      default: s = '0;
    endcase
    return s;
  endfunction

  ghb_pkg::ghb_strb_t strb_d;
  logic               any_rd_d;
  logic               any_wr_d;
  logic               any_rd_q;
  logic               any_wr_q;

  // only a configured port passes strobes
  always_comb begin
    strb_d   = cfg_o.valid ? map_strb(cfg_o.style, pin_s) : '0;
    any_rd_d = strb_d.rd_hi | strb_d.rd_lo;
    any_wr_d = strb_d.wr_hi | strb_d.wr_lo;
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      strb_o     <= '0;
      any_rd_q   <= 1'b0;
      any_wr_q   <= 1'b0;
      rd_start_o <= 1'b0;
      wr_start_o <= 1'b0;
    end else if (ce_i) begin
      strb_o     <= strb_d;
      any_rd_q   <= any_rd_d;
      any_wr_q   <= any_wr_d;
      rd_start_o <= any_rd_d & ~any_rd_q;
      wr_start_o <= any_wr_d & ~any_wr_q;
    end
  end

  // ---------------------------------------------------------------------------
  // address decode; bits 16 and up fold away, so the space aliases
  // ---------------------------------------------------------------------------
  function automatic ghb_pkg::ghb_dec_t dec_addr(input logic [15:0] a);
    ghb_pkg::ghb_dec_t d;
    d.offset  = a;
    d.mem_hit = (a <= ghb_pkg::MEM_LAST);
    d.reg_hit = (a >= ghb_pkg::REG_FIRST);
    return d;
  endfunction

  // synchronised address lags like the strobes; a raw read would catch the next address
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dec_o <= '0;
    end else if (ce_i && (any_rd_d | any_wr_d)) begin
      dec_o <= dec_addr(addr_s);
    end
  end

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  AST_CFG_STABLE: assert property (ce_i && $past(cfg_o.valid) |-> $stable(cfg_o))
    else $error("config changed after capture");
  AST_STYLE_TWO: assert property ((cap_q == GHB_ST_LATCH && ce_i && strap_s[2:0] == 3'h7
      && strap_s[5]) |=> cfg_o.style == ghb_pkg::GHB_STYLE_TWO)
    else $error("style two not selected");
  AST_STYLE_ONE: assert property ((cap_q == GHB_ST_LATCH && ce_i && strap_s[2:0] == 3'h7
      && !strap_s[5]) |=> cfg_o.style == ghb_pkg::GHB_STYLE_ONE)
    else $error("style one not selected");
  AST_ENDIAN: assert property ((cap_q == GHB_ST_LATCH && ce_i)
      |=> cfg_o.big_endian == $past(strap_s[3]))
    else $error("endian strap not captured");
  AST_CAPTURE_ONCE: assert property ((cap_q == GHB_ST_RUN) |=> cap_q == GHB_ST_RUN)
    else $error("strap capture repeated");
  AST_S2_WR: assert property ((ce_i && cfg_o.valid && cfg_o.style == ghb_pkg::GHB_STYLE_TWO
      && $stable(cfg_o)) |=> strb_o.wr_lo == $past(pin_s[2]))
    else $error("style two write mismatch");
  AST_S1_RDHI: assert property ((ce_i && cfg_o.valid && cfg_o.style == ghb_pkg::GHB_STYLE_ONE
      && $stable(cfg_o)) |=> strb_o.rd_hi == $past(pin_s[0]))
    else $error("style one high read mismatch");
  AST_REG_DEC: assert property ((ce_i && (any_rd_d | any_wr_d)
      && addr_s >= ghb_pkg::REG_FIRST) |=> dec_o.reg_hit && !dec_o.mem_hit)
    else $error("register window not decoded");
  AST_RD_PULSE: assert property (rd_start_o |=> !rd_start_o)
    else $error("read start longer than a cycle");

  COV_STYLE_ONE: cover property (cfg_o.valid && cfg_o.style == ghb_pkg::GHB_STYLE_ONE);
  COV_STYLE_TWO: cover property (cfg_o.valid && cfg_o.style == ghb_pkg::GHB_STYLE_TWO);
  COV_REG_WR:    cover property (wr_start_o ##1 dec_o.reg_hit);
  COV_MEM_RD:    cover property (rd_start_o ##1 dec_o.mem_hit);

endmodule

`default_nettype wire

// >>> verif/ghb_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// ---------------------------------------------------------------
// host side: strobe pins and the externally latched address
// ---------------------------------------------------------------
module ghb_host_model (
  // clock
  input  wire logic        clk_sys_i,
  // pins toward the port, strobes active low
  output logic      [3:0]  pins_n_o,
  output logic      [25:0] addr_o
);
  // idle strobes high before the first access
  initial begin
    pins_n_o = 4'hf;
    addr_o   = 26'h0;
  end

  // bits {rd_wr, rd, we1, we0}; strobe low 4 cycles, high 4 cycles
  task automatic access(input logic [3:0] p, input logic [25:0] a);
    @(negedge clk_sys_i);
    addr_o   = a;
    pins_n_o = ~p;
    repeat (4) @(negedge clk_sys_i);
    pins_n_o = 4'hf;
    addr_o   = ~a;      // address no longer held, show its inverse
    repeat (4) @(negedge clk_sys_i);
  endtask
endmodule
`default_nettype wire

// >>> verif/ghb_host_port_tb.sv
`timescale 1ns/10ps
`default_nettype none

module ghb_host_port_tb;
  // ---------------------------------------------------------------
  // stimulus and observation
  // ---------------------------------------------------------------
  logic               clk_sys_i = 1'b0;
  logic               resetn_i  = 1'b0;
  logic               ce        = 1'b1;
  logic [4:0]         straps    = 5'h0;
  logic               style_sel = 1'b0;
  logic [3:0]         pins_n;
  logic [25:0]        addr;
  ghb_pkg::ghb_cfg_t  cfg;
  ghb_pkg::ghb_strb_t strb;
  ghb_pkg::ghb_dec_t  dec;
  logic               rd_start;
  logic               wr_start;
  int                 fails      = 0;
  int                 num_checks = 0;
  ghb_pkg::ghb_style_t exp_style = ghb_pkg::GHB_STYLE_NONE;

  always #10 clk_sys_i = ~clk_sys_i;

  // a single host model drives the strobe pins and the address
  ghb_host_model i_ghb_host_model (
    .clk_sys_i (clk_sys_i),
    .pins_n_o  (pins_n),
    .addr_o    (addr)
  );

  ghb_host_port i_ghb_host_port (
    .clk_sys_i                  (clk_sys_i),
    .resetn_i                   (resetn_i),
    .ce_i                       (ce),
    .config_straps_i            (straps),
    .bus_style_select_i         (style_sel),
    .high_byte_write_strobe_n_i (pins_n[1]),
    .low_byte_write_strobe_n_i  (pins_n[0]),
    .read_n_i                   (pins_n[2]),
    .read_write_n_i             (pins_n[3]),
    .addr_i                     (addr),
    .cfg_o                      (cfg),
    .strb_o                     (strb),
    .dec_o                      (dec),
    .rd_start_o                 (rd_start),
    .wr_start_o                 (wr_start)
  );

  // ---------------------------------------------------------------
  // expectations and reporting
  // ---------------------------------------------------------------
  function automatic ghb_pkg::ghb_strb_t exp_strb(input ghb_pkg::ghb_style_t s,
                                                  input logic [3:0] p);
    exp_strb = '0;
    if (s == ghb_pkg::GHB_STYLE_ONE) exp_strb = p;
    if (s == ghb_pkg::GHB_STYLE_TWO) exp_strb = {p[2] & p[1], p[2], p[0] & p[1], p[0]};
  endfunction

  // low 16 bits only, so every 64k alias decodes alike
  function automatic ghb_pkg::ghb_dec_t exp_dec(input logic [25:0] a);
    exp_dec.offset  = a[15:0];
    exp_dec.mem_hit = a[15:0] <= ghb_pkg::MEM_LAST;
    exp_dec.reg_hit = a[15:0] >= ghb_pkg::REG_FIRST;
  endfunction

  task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic final_report();
    if (fails == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // reset with given straps, then wiggle straps to show they are held
  task automatic power_up(input logic [2:0] it, input logic sel, input logic big);
    ghb_pkg::ghb_cfg_t e;
    int n;
    @(negedge clk_sys_i);
    resetn_i  = 1'b0;
    straps    = {1'($urandom), big, it};
    style_sel = sel;
    repeat (20) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    ce       = 1'b0;
    repeat (12) @(negedge clk_sys_i);
    chk_val("cfg_o frozen", 0, cfg);
    ce = 1'b1;
    n = 0;
    while (cfg.valid !== 1'b1 && n < 30) begin
      @(negedge clk_sys_i);
      n++;
    end
    if (n == 30) begin
      fails++;
      final_report();
    end
    e.valid      = 1'b1;
    e.big_endian = big;
    e.style      = (it != ghb_pkg::IFTYPE_GENERIC) ? ghb_pkg::GHB_STYLE_NONE :
                   sel ? ghb_pkg::GHB_STYLE_TWO : ghb_pkg::GHB_STYLE_ONE;
    exp_style    = e.style;
    chk_val("cfg_o", e, cfg);
    straps    = 5'($urandom);
    style_sel = ~sel;
    repeat (10) @(negedge clk_sys_i);
    chk_val("cfg_o held", e, cfg);
  endtask

  // one host access with the port's answer checked against it
  task automatic access(input logic [3:0] p, input logic [25:0] a);
    ghb_pkg::ghb_strb_t es;
    logic rd;
    logic wr;
    int n;
    es = exp_strb(exp_style, p);
    rd = es.rd_lo | es.rd_hi;
    wr = es.wr_lo | es.wr_hi;
    n  = 0;
    fork
      i_ghb_host_model.access(p, a);
      begin
        while (rd_start !== 1'b1 && wr_start !== 1'b1 && n < 8) begin
          @(posedge clk_sys_i);
          #1;
          n++;
        end
        if (n == 8 && (rd | wr)) begin
          fails++;
          final_report();
        end
        chk_val("rd_start_o", rd, rd_start);
        chk_val("wr_start_o", wr, wr_start);
        chk_val("strb_o", es, strb);
        if (rd | wr) begin
          chk_val("dec_o", exp_dec(a), dec);
          @(posedge clk_sys_i);
          #1;
          chk_val("start width", 0, rd_start | wr_start);
        end
      end
    join
    chk_val("strb_o idle", 0, strb);
  endtask

  // ---------------------------------------------------------------
  // main sequence: all 8 combinations of generic or not, style select and endian, corner offsets first
  // ---------------------------------------------------------------
  initial begin
    logic [15:0] corner [6];
    logic [15:0] off;
    logic [3:0]  p;
    logic [25:0] adr;
    corner = '{16'h0000, 16'h9fff, 16'ha000, 16'hffdf, 16'hffe0, 16'hffff};
    void'($urandom(117));
    for (int k = 0; k < 8; k++) begin
      power_up(k[2] ? ghb_pkg::IFTYPE_GENERIC : 3'($urandom_range(6, 0)), k[0], k[1]);
      for (int j = 0; j < 12; j++) begin
        off = (j < 6) ? corner[j] : 16'($urandom);
        p   = j[0] ? {2'($urandom_range(3, 1)), 2'b00} : {2'b00, 2'($urandom_range(3, 1))};
        if (exp_style == ghb_pkg::GHB_STYLE_TWO)
          p = {1'b0, j[0], 1'($urandom), ~j[0]};
        // slot window base, then a random one of its 256 aliases
        adr = 26'(k[0] ? ghb_pkg::WIN_SLOT2_BASE : ghb_pkg::WIN_SLOT1_BASE);
        adr = adr | {2'h0, 8'($urandom), off};
        access(p, adr);
      end
    end
    final_report();
  end
endmodule
`default_nettype wire
